// File: hdl/pwm_pkg.sv
// Register map, reset values and timing constants of the pulse-division PWM
package pwm_pkg;
   localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'hFFD0;
   localparam logic [15:0] ADDR_WIDTH_UPPER = 16'hFFD1;
   localparam logic [15:0] ADDR_WIDTH_LOWER = 16'hFFD2;
   localparam logic [7:0] CLOCK_CONTROL_RESET = 8'hFE;
   localparam logic [7:0] WIDTH_UPPER_RESET = 8'hC0;
   localparam logic [7:0] WIDTH_LOWER_RESET = 8'h00;
   localparam logic [7:0] READ_ALL_ONES = 8'hFF;
   localparam int PERIOD_SEL_BIT = 0;
   localparam int UPPER_DATA_BITS = 6;
   localparam int LOWER_DATA_BITS = 8;
   localparam int DATA_BITS = UPPER_DATA_BITS + LOWER_DATA_BITS;
   localparam int PULSE_COUNT = 64;
   localparam int PULSE_BITS = 6;
   localparam int SLOT_BITS = DATA_BITS - PULSE_BITS;
   localparam logic [DATA_BITS:0] BASE_HALF_STEPS = 15'h0040;
endpackage

// File: hdl/pulse_division_dac_pwm.sv
// Pulse-division 14-bit PWM generator with write-only register port
`timescale 1ns/1ps
// Overview of operation
// - With period select 0 the generator steps every system clock, period 16,384 clocks.
// - With period select 1 the generator steps every 2 system clocks, period 32,768 clocks.
// - Clock control bits 7 to 1 read as ones and ignore writes.
// - Period select is write-only and its bit position always reads as one.
// - Reset loads the clock control register with FE, selecting the short period.
// - The width value is 6 upper bits from the high register and 8 from the low register.
// - The value sets the total high time over a whole period, not one pulse.
// - Writing the high register moves both registers into the generator as one value.
// - Both data registers are write-only and read back as all ones.
// - Reset sets the data pair to C000, all data bits zero.
// - A period is 64 pulses whose high time totals (data+64) half input clocks, at most 16,384.
// - The input clock period is 2 system clocks for select 0 and 4 for select 1.
module pulse_division_dac_pwm
   import pwm_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic pwm_out
);

   logic period_sel_q;
   logic [7:0] width_upper_q;
   logic [7:0] width_lower_q;
   logic [DATA_BITS-1:0] pending_q;
   logic [DATA_BITS-1:0] active_q;
   logic [1:0] half_div_q;
   logic [SLOT_BITS-1:0] slot_q;
   logic [PULSE_BITS-1:0] pulse_q;
   logic tick;
   logic period_end;
   logic [SLOT_BITS+1:0] high_half_steps;
   logic extra_half;
   logic [SLOT_BITS+1:0] half_pos;
   logic pwm_d;
   logic unused_div_bit;

   // Bit-reversal of the pulse index spreads the extra half-steps evenly
   function automatic logic [PULSE_BITS-1:0] bit_rev(input logic [PULSE_BITS-1:0] v);
      logic [PULSE_BITS-1:0] r;
      r = '0;
      for (int i = 0; i < PULSE_BITS; i++) begin
         r[i] = v[PULSE_BITS-1-i];
      end
      return r;
   endfunction

   // Register writes; reserved bits are not stored at all
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         period_sel_q <= CLOCK_CONTROL_RESET[PERIOD_SEL_BIT];
      end else if (wr && addr == ADDR_CLOCK_CONTROL) begin
         period_sel_q <= wdata[PERIOD_SEL_BIT];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         width_upper_q <= WIDTH_UPPER_RESET;
         width_lower_q <= WIDTH_LOWER_RESET;
      end else begin
         if (wr && addr == ADDR_WIDTH_LOWER) begin
            width_lower_q <= wdata;
         end
         if (wr && addr == ADDR_WIDTH_UPPER) begin
            width_upper_q <= {WIDTH_UPPER_RESET[7:UPPER_DATA_BITS],
                              wdata[UPPER_DATA_BITS-1:0]};
         end
      end
   end

   // Upper write latches the whole 14-bit value; relies on low written first
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pending_q <= '0;
      end else if (wr && addr == ADDR_WIDTH_UPPER) begin
         pending_q <= {wdata[UPPER_DATA_BITS-1:0], width_lower_q};
      end
   end

   // Reads: every location is write-only, so all ones
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         rdata <= READ_ALL_ONES;
      end else begin
         rdata <= '0;
      end
   end

   // Half-step divider: system clock /2 or /4 per input clock
   always_ff @(posedge ref_clk) begin
      if (rst || tick) begin
         half_div_q <= '0;
      end else begin
         half_div_q <= half_div_q + 2'h1;
      end
   end
   // One tick is half an input clock: 1 system clock or 2
   assign tick = period_sel_q ? (half_div_q == 2'h1) : 1'b1;

   // Each pulse holds 2^SLOT_BITS half-steps; slot counts half-steps directly
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         slot_q <= '0;
         pulse_q <= '0;
      end else if (tick) begin
         slot_q <= slot_q + 1'b1;
         if (&slot_q) begin
            pulse_q <= pulse_q + 1'b1;
         end
      end
   end
   // Divider only ever reaches 1 before wrapping
   assign unused_div_bit = half_div_q[1];

   assign period_end = tick && (&slot_q) && (&pulse_q);

   // New value only at a period boundary, so a period is never mixed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         active_q <= '0;
      end else if (period_end) begin
         active_q <= pending_q;
      end
   end

   // Per pulse: (data>>6)+1 half-steps base, plus one for the low 6 bits
   // selected pulses, totalling data+64 over the period, at most 16384
   assign extra_half = bit_rev(pulse_q) < active_q[PULSE_BITS-1:0];
   assign high_half_steps = (SLOT_BITS+2)'(active_q[DATA_BITS-1:PULSE_BITS])
                            + (SLOT_BITS+2)'(1) + (SLOT_BITS+2)'(extra_half);
   assign half_pos = {2'b00, slot_q};
   // Counts of 256 or more keep the pin high for the whole pulse
   assign pwm_d = half_pos < high_half_steps;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwm_out <= 1'b0;
      end else begin
         pwm_out <= pwm_d;
      end
   end

endmodule

// File: tb/pwm_sva.sv
// Port assertions for the PWM block
`timescale 1ns/1ps
module pwm_sva
   import pwm_pkg::*;
(
   input logic ref_clk,
   input logic rst,
   input logic [15:0] addr,
   input logic [7:0] wdata,
   input logic wr,
   input logic rd,
   input logic [7:0] rdata,
   input logic pwm_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_read_ones: assert property (rd |=> rdata == READ_ALL_ONES) else $error("read");
   chk_idle_zero: assert property (!rd |=> rdata == 8'h00) else $error("idle");
   chk_ctl_ones: assert property (rd && addr == ADDR_CLOCK_CONTROL |=> &rdata[7:1])
      else $error("ctl");
   chk_sel_ones: assert property (wr && !wdata[0] ##2 rd |=> rdata[0]) else $error("sel");
   chk_rst_quiet: assert property (disable iff (1'b0) rst |=> !pwm_out && rdata == 8'h00)
      else $error("reset");
   chk_first_pulse: assert property ($fell(rst) |-> ##[0:600] pwm_out) else $error("start");
   chk_high_ends: assert property (pwm_out |-> ##[1:600] !pwm_out) else $error("high");
   chk_low_ends: assert property (!pwm_out |-> ##[1:600] pwm_out) else $error("low");
   cover property (wr && addr == ADDR_WIDTH_UPPER);
   cover property (rd && addr == ADDR_CLOCK_CONTROL);
   cover property ($rose(pwm_out));
endmodule
bind pulse_division_dac_pwm pwm_sva pwm_sva_inst (.ref_clk, .rst, .addr, .wdata, .wr, .rd,
   .rdata, .pwm_out);

// File: tb/lpf_model.sv
// Filter stand-in: integrates the high time on the pin
`timescale 1ns/1ps
module lpf_model (
   input logic ref_clk,
   input logic pwm_out,
   output logic [31:0] charge = 32'h0
);
   always @(posedge ref_clk) charge <= charge + {31'h0, pwm_out};
endmodule

// File: tb/tb.sv
// Bench: register reads and summed high time per period
`timescale 1ns/1ps
module tb;
   import pwm_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pwm_out;
   logic [15:0] addr = 16'h0;
   logic [7:0] wdata = 8'h0, rdata;
   logic [31:0] charge, seed = 32'h17;
   int errors, checks_done;
   pulse_division_dac_pwm pulse_division_dac_pwm_inst (.ref_clk, .rst, .addr, .wdata, .wr,
      .rd, .rdata, .pwm_out);
   lpf_model lpf_model_inst (.ref_clk, .pwm_out, .charge);
   initial forever #2.5 ref_clk = ~ref_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] high_time(input logic [13:0] d, input logic s);
      return ({18'h0, d} + 32'h40) << s;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
      end
   endtask
   // Two cycles per access so strobes never re-rise in the same step
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      {wr, rd, addr, wdata} <= {w, !w, a, d};
      @(posedge ref_clk);
      {wr, rd} <= 2'b00;
      #1;
      if (!w) check({24'h0, rdata}, 32'hFF);
      @(posedge ref_clk);
   endtask
   // Any full-period window sums the same, so phase need not be known
   task automatic measure(input logic [13:0] d, input logic s);
      logic [31:0] c0;
      repeat (s ? 32'h8008 : 32'h4008) @(posedge ref_clk);
      c0 = charge;
      repeat (s ? 32'h8000 : 32'h4000) @(posedge ref_clk);
      check(charge - c0, high_time(d, s));
   endtask
   task automatic tally_and_finish;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      seed = xs(seed);
      bus(1'b1, ADDR_CLOCK_CONTROL, 8'h00); // period before data
      for (int i = 0; i < 4; i++)
         bus(1'b0, ADDR_CLOCK_CONTROL + 16'(i), seed[7:0]);
      bus(1'b1, ADDR_WIDTH_LOWER, seed[7:0]); // low byte first
      bus(1'b1, ADDR_WIDTH_UPPER, {seed[15:14], 1'b0, seed[12:8]});
      measure({1'b0, seed[12:0]}, 1'b0);
      // Data before the mode switch so no boundary can latch stale data late
      bus(1'b1, ADDR_WIDTH_LOWER, 8'h00);
      bus(1'b1, ADDR_WIDTH_UPPER, 8'hC0); // top bits ignored
      bus(1'b1, ADDR_CLOCK_CONTROL, 8'h01);
      measure(14'h0, 1'b1); // zero width corner
      tally_and_finish();
   end
   initial begin
      #510000;
      errors++;
      tally_and_finish();
   end
endmodule
